/* shared/iolc_pkg.sv */
// package: register map, field layout and carriers of the io line controller
`default_nettype none
package iolc_pkg;
  localparam int IOLC_NL = 32;
  // register byte offsets
  localparam logic [11:0] OFS_LINE_EN = 12'h000;
  localparam logic [11:0] OFS_LINE_DIS = 12'h004;
  localparam logic [11:0] OFS_LINE_ST = 12'h008;
  localparam logic [11:0] OFS_OE_SET = 12'h010;
  localparam logic [11:0] OFS_OE_CLR = 12'h014;
  localparam logic [11:0] OFS_OE_ST = 12'h018;
  localparam logic [11:0] OFS_GF_ON = 12'h020;
  localparam logic [11:0] OFS_GF_OFF = 12'h024;
  localparam logic [11:0] OFS_GF_ST = 12'h028;
  localparam logic [11:0] OFS_DRV_HI = 12'h030;
  localparam logic [11:0] OFS_DRV_LO = 12'h034;
  localparam logic [11:0] OFS_OUT_ST = 12'h038;
  localparam logic [11:0] OFS_PIN_SMP = 12'h03C;
  localparam logic [11:0] OFS_IRQ_UNM = 12'h040;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h044;
  localparam logic [11:0] OFS_IRQ_MST = 12'h048;
  localparam logic [11:0] OFS_IRQ_PEND = 12'h04C;
  localparam logic [11:0] OFS_OD_ON = 12'h050;
  localparam logic [11:0] OFS_OD_OFF = 12'h054;
  localparam logic [11:0] OFS_OD_ST = 12'h058;
  localparam logic [11:0] OFS_PU_OFF = 12'h060;
  localparam logic [11:0] OFS_PU_ON = 12'h064;
  localparam logic [11:0] OFS_PU_ST = 12'h068;
  localparam logic [11:0] OFS_SEL_LO = 12'h070;
  localparam logic [11:0] OFS_SEL_HI = 12'h074;
  localparam logic [11:0] OFS_DB_OFF = 12'h080;
  localparam logic [11:0] OFS_DB_ON = 12'h084;
  localparam logic [11:0] OFS_DB_ST = 12'h088;
  localparam logic [11:0] OFS_DB_DIV = 12'h08C;
  localparam logic [11:0] OFS_PD_OFF = 12'h090;
  localparam logic [11:0] OFS_PD_ON = 12'h094;
  localparam logic [11:0] OFS_PD_ST = 12'h098;
  localparam logic [11:0] OFS_DW_ON = 12'h0A0;
  localparam logic [11:0] OFS_DW_OFF = 12'h0A4;
  localparam logic [11:0] OFS_DW_ST = 12'h0A8;
  localparam logic [11:0] OFS_AIM_ON = 12'h0B0;
  localparam logic [11:0] OFS_AIM_OFF = 12'h0B4;
  localparam logic [11:0] OFS_AIM_ST = 12'h0B8;
  localparam logic [11:0] OFS_EDGE_SEL = 12'h0C0;
  localparam logic [11:0] OFS_LVL_SEL = 12'h0C4;
  localparam logic [11:0] OFS_TRIG_ST = 12'h0C8;
  localparam logic [11:0] OFS_FALL_SEL = 12'h0D0;
  localparam logic [11:0] OFS_RISE_SEL = 12'h0D4;
  localparam logic [11:0] OFS_POL_ST = 12'h0D8;
  localparam logic [11:0] OFS_LOCK_ST = 12'h0E0;
  localparam logic [11:0] OFS_WG_MODE = 12'h0E4;
  localparam logic [11:0] OFS_WG_ST = 12'h0E8;
  localparam logic [11:0] OFS_HYST = 12'h100;
  localparam logic [11:0] OFS_CAP_MODE = 12'h150;
  localparam logic [11:0] OFS_CAP_ST = 12'h160;
  localparam logic [11:0] OFS_CAP_DATA = 12'h164;
  // field positions
  localparam int WG_ON_BIT = 0;
  localparam int WG_KEY_LSB = 8;
  localparam int WGV_BIT = 0;
  localparam int WGV_SRC_LSB = 8;
  localparam int CAP_EN_BIT = 0;
  localparam int CAP_RDY_BIT = 0;
  localparam int CAP_OVR_BIT = 1;
  // guard key, value arbitrary
  localparam logic [23:0] WG_KEY = 24'h5A3C96;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // pad drive bundle
  typedef struct packed {
    logic [31:0] drv_oe;
    logic [31:0] drv_out;
    logic [31:0] pull_up;
    logic [31:0] pull_dn;
    logic [31:0] schmitt;
  } iolc_pad_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WR = 2'b10
  } iolc_bus_st_t;
endpackage
`default_nettype wire

/* verif/iolc_pad_model.sv */
// pad model: resolves each pad from controller, far side and pull-ups
`default_nettype none
module iolc_pad_model
  import iolc_pkg::*;
(
  // controller side
  input wire iolc_pad_t i_pad,
  // far-side drivers
  input wire logic [31:0] i_ext_en,
  input wire logic [31:0] i_ext_val,
  // resolved pad levels
  output logic [31:0] o_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // a released line with no far-side driver takes its pull-up, never keeps the last driven value
  always_comb begin
    o_level = (i_pad.drv_oe & i_pad.drv_out)
      | (~i_pad.drv_oe & i_ext_en & i_ext_val)
      | (~i_pad.drv_oe & ~i_ext_en & i_pad.pull_up);
  end
endmodule
`default_nettype wire

/* verif/test_io_line_controller_register_map.sv */
// testbench: register map, pads, interrupt, guard and capture
`default_nettype none
module test_io_line_controller_register_map
  import iolc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] IMPL = 32'h7FFF_FFFF;
  localparam logic [31:0] MUXM = 32'hFFFF_0000;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, capv = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, capd = 32'h0, pext = 32'h0;
  logic [31:0] hrdata, owned, sel_lo, sel_hi, pin, v, w, got;
  logic hready, hresp, irq;
  iolc_pad_t pad;
  int bad_count = 0, comparisons = 0, cyc = 0;
  integer seed = 32'h0db7;
  logic [31:0] expq[$];
  event got_ev;
  logic [11:0] rofs [17] = '{OFS_OE_ST, OFS_GF_ST, OFS_IRQ_MST, OFS_IRQ_PEND,
    OFS_OD_ST, OFS_SEL_LO, OFS_SEL_HI, OFS_DB_ST, OFS_DB_DIV, OFS_DW_ST,
    OFS_AIM_ST, OFS_TRIG_ST, OFS_POL_ST, OFS_LOCK_ST, OFS_WG_MODE, OFS_WG_ST,
    OFS_HYST};
  logic [11:0] rwofs [4] = '{OFS_SEL_LO, OFS_SEL_HI, OFS_DB_DIV, OFS_HYST};
  logic [11:0] sc [11][3] = '{'{OFS_OE_SET, OFS_OE_CLR, OFS_OE_ST},
    '{OFS_GF_ON, OFS_GF_OFF, OFS_GF_ST}, '{OFS_OD_ON, OFS_OD_OFF, OFS_OD_ST},
    '{OFS_DW_ON, OFS_DW_OFF, OFS_DW_ST}, '{OFS_PU_ON, OFS_PU_OFF, OFS_PU_ST},
    '{OFS_PD_ON, OFS_PD_OFF, OFS_PD_ST}, '{OFS_DB_ON, OFS_DB_OFF, OFS_DB_ST},
    '{OFS_AIM_ON, OFS_AIM_OFF, OFS_AIM_ST},
    '{OFS_LVL_SEL, OFS_EDGE_SEL, OFS_TRIG_ST},
    '{OFS_RISE_SEL, OFS_FALL_SEL, OFS_POL_ST},
    '{OFS_LINE_EN, OFS_LINE_DIS, OFS_LINE_ST}};
  logic [11:0] resv [4] = '{12'h00C, 12'h0F0, 12'h170, 12'h18C};

  iolc_ctrl #(.IMPL_MASK(IMPL), .MUX_MASK(MUXM)) iolc_ctrl_inst (
    .i_core_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_pad_in(pin), .i_periph_oe(32'h0),
    .i_periph_out(32'h0), .o_pad(pad), .o_line_owned(owned),
    .o_sel_low(sel_lo), .o_sel_high(sel_hi), .i_cap_valid(capv),
    .i_cap_data(capd), .o_irq(irq));
  iolc_pad_model iolc_pad_model_inst (.i_pad(pad), .i_ext_en(32'hFFFF_FFFF),
    .i_ext_val(pext), .o_level(pin));

  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hangs are cut short here; the ceiling is about fifty times the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  always @(got_ev) check(got, expq.pop_front());
  ////////////////////////////////////////////////////////////////////////////
  // entered just after a rising edge; no fixed latency is assumed
  task automatic bus(input logic [11:0] a, input logic wr,
      input logic [31:0] d, input logic chk, input logic [31:0] e);
    if (chk) expq.push_back(e);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    if (chk) begin
      got = hrdata;
      ->got_ev;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'h1, d, 1'h0, 32'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0, 1'h1, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    foreach (rofs[i]) rd(rofs[i], RST_ZERO);
    rd(OFS_LINE_ST, IMPL);
    $display("test reset values done");
    foreach (rwofs[i]) begin
      v = $random(seed);
      wr(rwofs[i], v);
      rd(rwofs[i], rwofs[i] == OFS_DB_DIV ? v : v & IMPL);
      if (i < 2) check(i == 0 ? sel_lo : sel_hi, v & IMPL);
    end
    $display("test read-write done");
    foreach (sc[i]) begin
      v = $random(seed);
      w = $random(seed);
      wr(sc[i][1], 32'hFFFF_FFFF);
      wr(sc[i][0], v);
      wr(sc[i][0], 32'h0);
      wr(sc[i][1], w);
      rd(sc[i][2], (v & ~w | (i == 10 ? ~MUXM : 32'h0)) & IMPL);
      if (i == 10) check(owned & IMPL, (v & ~w | ~MUXM) & IMPL);
      wr(sc[i][1], 32'hFFFF_FFFF);
    end
    wr(OFS_LINE_EN, 32'hFFFF_FFFF);
    $display("test set and clear done");
    wr(OFS_DW_ON, 32'h0000_00FF);
    wr(OFS_DRV_LO, 32'hFFFF_FFFF);
    wr(OFS_OUT_ST, 32'hFFFF_FFFF);
    rd(OFS_OUT_ST, 32'h0000_00FF);
    wr(OFS_DRV_HI, 32'h8000_0F00);
    rd(OFS_OUT_ST, 32'h0000_0FFF);
    wr(OFS_OE_SET, 32'h0000_00F0);
    wr(OFS_OD_ON, 32'h0000_0030);
    // the pad register settles one edge after the commit
    tick(1);
    check(pad.drv_oe, 32'h0000_00C0);
    check(pad.drv_out, 32'h0000_0FFF);
    wr(OFS_OE_CLR, 32'h0000_00F0);
    wr(OFS_OD_OFF, 32'h0000_0030);
    $display("test output level done");
    v = $random(seed);
    pext <= v;
    tick(5);
    rd(OFS_PIN_SMP, v & IMPL);
    bus(OFS_IRQ_PEND, 1'h0, 32'h0, 1'h0, 32'h0);
    wr(OFS_IRQ_UNM, 32'h0000_0008);
    pext <= v ^ 32'h0000_0008;
    tick(6);
    check({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_PEND, 32'h0000_0008);
    tick(2);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MSK, 32'h0000_0008);
    pext <= v;
    tick(6);
    check({31'h0, irq}, 32'h0);
    rd(OFS_IRQ_PEND, 32'h0000_0008);
    $display("test pins and interrupt done");
    wr(OFS_GF_ON, 32'h0000_0001);
    pext <= v ^ 32'h0000_0001;
    @(posedge clk);
    pext <= v;
    tick(6);
    rd(OFS_PIN_SMP, v & IMPL);
    rd(OFS_IRQ_PEND, RST_ZERO);
    wr(OFS_GF_OFF, 32'h0000_0001);
    wr(OFS_SEL_LO, 32'h0);
    wr(OFS_WG_MODE, {WG_KEY, 8'h01});
    wr(OFS_SEL_LO, 32'h0000_1234);
    rd(OFS_SEL_LO, RST_ZERO);
    check(sel_lo, RST_ZERO);
    rd(OFS_WG_ST, 32'h0000_7001);
    wr(OFS_WG_MODE, {WG_KEY, 8'h00});
    rd(OFS_WG_ST, 32'h0000_7000);
    $display("test write guard done");
    foreach (resv[i]) begin
      wr(resv[i], $random(seed));
      rd(resv[i], RST_ZERO);
    end
    check({31'h0, hresp}, 32'h0);
    $display("test reserved done");
    wr(OFS_CAP_MODE, 32'h0000_0001);
    v = $random(seed);
    w = $random(seed);
    capv <= 1'h1;
    capd <= v;
    @(posedge clk);
    capd <= w;
    @(posedge clk);
    capv <= 1'h0;
    tick(2);
    rd(OFS_CAP_ST, 32'h0000_0003);
    rd(OFS_CAP_ST, 32'h0000_0001);
    rd(OFS_CAP_DATA, w);
    rd(OFS_CAP_ST, RST_ZERO);
    $display("test capture done");
    tick(2);
    conclude();
  end
endmodule
`default_nettype wire

/* verilog/iolc_ctrl.sv */
// io line controller: ahb-lite register file, pad control, filters, irq
//
// Overview of operation
// - all registers 32 bits; bit n of per-line registers acts on line n
// - writes to bits of unimplemented lines are ignored, state unchanged
// - bits of unimplemented lines always read zero
// - lines without peripheral are always owned, ownership bit reads one
// - output level register directly writable only where direct write is enabled; set/clear acts on all lines
// - pin sample register tracks pins only while the clock runs
// - irq pending resets to zero; later input changes are latched
// - unassigned offsets are reserved; software relies on nothing there
// - two peripheral select registers, read-write, reset zero, 2 bits/line
// - guard mode read-write reset zero; guard state read-only reset zero
// - debounce divider read-write, reset zero, sets slow debounce rate
// - offsets 0x168 to 0x18C kept free for dma channel registers
// - glitch filter state resets zero, all filters off
// - extra irq mode state resets zero, plain change interrupts
// - writing 1 sets or clears the status bit; writing 0 does nothing
// - guarded writes blocked while guard on; violation and source logged
// - capture overrun set on lost data, cleared by reading capture status
`default_nettype none
module iolc_ctrl
  import iolc_pkg::*;
#(
  parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF,
  parameter logic [31:0] MUX_MASK = 32'hFFFF_FFFF,
  parameter logic [31:0] PU_RESET = 32'hFFFF_FFFF,
  parameter logic [31:0] PD_RESET = 32'h0000_0000
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // pads and peripheral functions
  input wire logic [31:0] i_pad_in,
  input wire logic [31:0] i_periph_oe,
  input wire logic [31:0] i_periph_out,
  output iolc_pad_t o_pad,
  output logic [31:0] o_line_owned,
  output logic [31:0] o_sel_low,
  output logic [31:0] o_sel_high,
  // parallel capture feed
  input wire logic i_cap_valid,
  input wire logic [31:0] i_cap_data,
  // interrupt
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: writes take one wait state so a following read sees them
  iolc_bus_st_t st_reg;
  logic [11:0] waddr_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic accept;
  logic rd_acc;
  logic commit;
  logic [31:0] wd;
  logic [31:0] rd_val;
  logic [11:0] raddr;

  assign accept = i_hsel & i_htrans[1] & i_hready;
  assign rd_acc = accept & ~i_hwrite & (st_reg == ST_IDLE);
  assign commit = (st_reg == ST_WR);
  assign raddr = i_haddr[11:0];
  assign wd = i_hwdata & IMPL_MASK;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= ST_IDLE;
      hready_reg <= 1'b1;
      waddr_reg <= 12'h000;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (accept && i_hwrite) begin
            st_reg <= ST_WR;
            hready_reg <= 1'b0;
            waddr_reg <= i_haddr[11:0];
          end
        end
        ST_WR: begin
          st_reg <= ST_IDLE;
          hready_reg <= 1'b1;
        end
        default: begin
          st_reg <= ST_IDLE;
          hready_reg <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration state
  logic [31:0] own_reg, oe_reg, gf_reg, out_reg, imask_reg, od_reg;
  logic [31:0] pu_reg, pd_reg, sel_lo_reg, sel_hi_reg, db_reg, div_reg;
  logic [31:0] dw_reg, aim_reg, elsr_reg, pol_reg, hyst_reg;
  logic wg_on_reg, wgv_reg, cap_en_reg;
  logic [11:0] wgsrc_reg;
  logic guarded;
  logic wr_ok;

  function automatic logic is_guarded(input logic [11:0] a);
    case (a)
      OFS_LINE_EN, OFS_LINE_DIS, OFS_OE_SET, OFS_OE_CLR, OFS_GF_ON,
      OFS_GF_OFF, OFS_OD_ON, OFS_OD_OFF, OFS_PU_OFF, OFS_PU_ON,
      OFS_SEL_LO, OFS_SEL_HI, OFS_DW_ON, OFS_DW_OFF, OFS_PD_OFF,
      OFS_PD_ON, OFS_CAP_MODE: is_guarded = 1'b1;
      default: is_guarded = 1'b0;
    endcase
  endfunction

  // set/clear pair: a 1 in set or clear moves the bit, a 0 leaves it
  function automatic logic [31:0] setclr(input logic [31:0] cur,
      input logic s, input logic c, input logic [31:0] d);
    setclr = s ? (cur | d) : (c ? (cur & ~d) : cur);
  endfunction

  assign guarded = wg_on_reg & is_guarded(waddr_reg);
  assign wr_ok = commit & ~guarded;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      own_reg <= 32'hFFFF_FFFF;
      oe_reg <= RST_ZERO;
      gf_reg <= RST_ZERO;
      od_reg <= RST_ZERO;
      pu_reg <= PU_RESET;
      pd_reg <= PD_RESET;
      sel_lo_reg <= RST_ZERO;
      sel_hi_reg <= RST_ZERO;
      db_reg <= RST_ZERO;
      div_reg <= RST_ZERO;
      dw_reg <= RST_ZERO;
      aim_reg <= RST_ZERO;
      elsr_reg <= RST_ZERO;
      pol_reg <= RST_ZERO;
      hyst_reg <= RST_ZERO;
      imask_reg <= RST_ZERO;
      cap_en_reg <= 1'b0;
    end else if (wr_ok) begin
      own_reg <= setclr(own_reg, waddr_reg == OFS_LINE_EN,
                        waddr_reg == OFS_LINE_DIS, wd) | ~MUX_MASK;
      oe_reg <= setclr(oe_reg, waddr_reg == OFS_OE_SET,
                       waddr_reg == OFS_OE_CLR, wd);
      gf_reg <= setclr(gf_reg, waddr_reg == OFS_GF_ON,
                       waddr_reg == OFS_GF_OFF, wd);
      od_reg <= setclr(od_reg, waddr_reg == OFS_OD_ON,
                       waddr_reg == OFS_OD_OFF, wd);
      pu_reg <= setclr(pu_reg, waddr_reg == OFS_PU_ON,
                       waddr_reg == OFS_PU_OFF, wd);
      pd_reg <= setclr(pd_reg, waddr_reg == OFS_PD_ON,
                       waddr_reg == OFS_PD_OFF, wd);
      db_reg <= setclr(db_reg, waddr_reg == OFS_DB_ON,
                       waddr_reg == OFS_DB_OFF, wd);
      dw_reg <= setclr(dw_reg, waddr_reg == OFS_DW_ON,
                       waddr_reg == OFS_DW_OFF, wd);
      aim_reg <= setclr(aim_reg, waddr_reg == OFS_AIM_ON,
                        waddr_reg == OFS_AIM_OFF, wd);
      elsr_reg <= setclr(elsr_reg, waddr_reg == OFS_LVL_SEL,
                         waddr_reg == OFS_EDGE_SEL, wd);
      pol_reg <= setclr(pol_reg, waddr_reg == OFS_RISE_SEL,
                        waddr_reg == OFS_FALL_SEL, wd);
      imask_reg <= setclr(imask_reg, waddr_reg == OFS_IRQ_UNM,
                          waddr_reg == OFS_IRQ_MSK, wd);
      if (waddr_reg == OFS_SEL_LO) sel_lo_reg <= wd;
      if (waddr_reg == OFS_SEL_HI) sel_hi_reg <= wd;
      if (waddr_reg == OFS_HYST) hyst_reg <= wd;
      if (waddr_reg == OFS_DB_DIV) div_reg <= i_hwdata;
      if (waddr_reg == OFS_CAP_MODE) cap_en_reg <= i_hwdata[CAP_EN_BIT];
    end
  end

  // output level: set/clear always, direct write only on enabled lines
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      out_reg <= RST_ZERO;
    end else if (commit) begin
      if (waddr_reg == OFS_DRV_HI) out_reg <= out_reg | wd;
      else if (waddr_reg == OFS_DRV_LO) out_reg <= out_reg & ~wd;
      else if (waddr_reg == OFS_OUT_ST)
        out_reg <= (out_reg & ~dw_reg) | (wd & dw_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write guard: key must match for mode writes; violations logged
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wg_on_reg <= 1'b0;
      wgv_reg <= 1'b0;
      wgsrc_reg <= 12'h000;
    end else if (commit) begin
      if (guarded) begin
        wgv_reg <= 1'b1;
        wgsrc_reg <= waddr_reg;
      end else if (waddr_reg == OFS_WG_MODE &&
                   i_hwdata[31:WG_KEY_LSB] == WG_KEY) begin
        wg_on_reg <= i_hwdata[WG_ON_BIT];
        wgv_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, glitch and debounce filters
  logic [31:0] pin_s1_reg, pin_s2_reg, last_reg, dblast_reg;
  logic [31:0] filt_reg, filt_next, prev_reg;
  logic [31:0] div_cnt_reg;
  logic tick;
  logic [31:0] g_ok, d_ok;

  // >= so a divider lowered mid-count still ticks at once
  assign tick = (div_cnt_reg >= div_reg);
  assign g_ok = ~(pin_s2_reg ^ last_reg);
  assign d_ok = tick ? ~(pin_s2_reg ^ dblast_reg) : RST_ZERO;
  // a slow tick trades response time for immunity to contact bounce
  assign filt_next = (~gf_reg & pin_s2_reg) |
      (gf_reg & ~db_reg & ((g_ok & pin_s2_reg) | (~g_ok & filt_reg))) |
      (gf_reg & db_reg & ((d_ok & pin_s2_reg) | (~d_ok & filt_reg)));

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pin_s1_reg <= RST_ZERO;
      pin_s2_reg <= RST_ZERO;
    end else begin
      pin_s1_reg <= i_pad_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_cnt_reg <= RST_ZERO;
      dblast_reg <= RST_ZERO;
    end else if (tick) begin
      div_cnt_reg <= RST_ZERO;
      dblast_reg <= pin_s2_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 32'h0000_0001;
    end
  end

  // with the clock gated these hold the last levels seen
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      last_reg <= RST_ZERO;
      filt_reg <= RST_ZERO;
      prev_reg <= RST_ZERO;
    end else begin
      last_reg <= pin_s2_reg;
      filt_reg <= filt_next & IMPL_MASK;
      prev_reg <= filt_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events; a set in the clearing cycle survives
  logic [31:0] pend_reg, ev, lvl_ok, chg;
  logic pend_clr;
  logic irq_reg;

  assign chg = filt_reg ^ prev_reg;
  assign lvl_ok = ~(filt_reg ^ pol_reg);
  assign ev = ((~aim_reg & chg) | (aim_reg & ~elsr_reg & chg & lvl_ok) |
               (aim_reg & elsr_reg & lvl_ok)) & IMPL_MASK;
  assign pend_clr = rd_acc & (raddr == OFS_IRQ_PEND);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_reg <= RST_ZERO;
      irq_reg <= 1'b0;
    end else begin
      pend_reg <= (pend_clr ? RST_ZERO : pend_reg) | ev;
      irq_reg <= |(pend_reg & imask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel capture holding register and overrun
  logic [31:0] cap_data_reg;
  logic cap_rdy_reg, cap_ovr_reg, cap_take, cap_st_rd, cap_dat_rd;

  assign cap_take = i_cap_valid & cap_en_reg;
  assign cap_st_rd = rd_acc & (raddr == OFS_CAP_ST);
  assign cap_dat_rd = rd_acc & (raddr == OFS_CAP_DATA);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cap_data_reg <= RST_ZERO;
      cap_rdy_reg <= 1'b0;
      cap_ovr_reg <= 1'b0;
    end else begin
      if (cap_take) cap_data_reg <= i_cap_data;
      cap_rdy_reg <= cap_take | (cap_rdy_reg & ~cap_dat_rd);
      if (cap_take && cap_rdy_reg && !cap_dat_rd)
        cap_ovr_reg <= 1'b1;
      else if (cap_st_rd)
        cap_ovr_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unlisted offsets, the dma window included, read zero
  always_comb begin
    case (raddr)
      OFS_LINE_ST: rd_val = own_reg & IMPL_MASK;
      OFS_OE_ST: rd_val = oe_reg & IMPL_MASK;
      OFS_GF_ST: rd_val = gf_reg & IMPL_MASK;
      OFS_OUT_ST: rd_val = out_reg & IMPL_MASK;
      OFS_PIN_SMP: rd_val = filt_reg & IMPL_MASK;
      OFS_IRQ_MST: rd_val = imask_reg & IMPL_MASK;
      OFS_IRQ_PEND: rd_val = pend_reg & IMPL_MASK;
      OFS_OD_ST: rd_val = od_reg & IMPL_MASK;
      OFS_PU_ST: rd_val = pu_reg & IMPL_MASK;
      OFS_SEL_LO: rd_val = sel_lo_reg & IMPL_MASK;
      OFS_SEL_HI: rd_val = sel_hi_reg & IMPL_MASK;
      OFS_DB_ST: rd_val = db_reg & IMPL_MASK;
      OFS_DB_DIV: rd_val = div_reg;
      OFS_PD_ST: rd_val = pd_reg & IMPL_MASK;
      OFS_DW_ST: rd_val = dw_reg & IMPL_MASK;
      OFS_AIM_ST: rd_val = aim_reg & IMPL_MASK;
      OFS_TRIG_ST: rd_val = elsr_reg & IMPL_MASK;
      OFS_POL_ST: rd_val = pol_reg & IMPL_MASK;
      OFS_WG_MODE: rd_val = {31'h0000_0000, wg_on_reg};
      OFS_WG_ST: rd_val = {12'h000, wgsrc_reg, 7'h00, wgv_reg};
      OFS_HYST: rd_val = hyst_reg & IMPL_MASK;
      OFS_CAP_MODE: rd_val = {31'h0000_0000, cap_en_reg};
      OFS_CAP_ST: rd_val = {30'h0000_0000, cap_ovr_reg, cap_rdy_reg};
      OFS_CAP_DATA: rd_val = cap_data_reg;
      default: rd_val = RST_ZERO;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) hrdata_reg <= RST_ZERO;
    else if (rd_acc) hrdata_reg <= rd_val;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive: open drain only pulls low
  iolc_pad_t pad_reg;
  logic [31:0] src_oe, src_out;

  assign src_oe = (own_reg & oe_reg) | (~own_reg & i_periph_oe);
  assign src_out = (own_reg & out_reg) | (~own_reg & i_periph_out);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pad_reg <= '0;
    end else begin
      pad_reg.drv_oe <= src_oe & ~(od_reg & src_out) & IMPL_MASK;
      pad_reg.drv_out <= src_out & IMPL_MASK;
      pad_reg.pull_up <= pu_reg & IMPL_MASK;
      pad_reg.pull_dn <= pd_reg & IMPL_MASK;
      pad_reg.schmitt <= hyst_reg & IMPL_MASK;
    end
  end

  assign o_pad = pad_reg;
  assign o_line_owned = own_reg;
  assign o_sel_low = sel_lo_reg;
  assign o_sel_high = sel_hi_reg;
  assign o_hrdata = hrdata_reg;
  assign o_hreadyout = hready_reg;
  assign o_hresp = 1'b0;
  assign o_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [31:0] d_wd;
  always_ff @(posedge i_core_clk) d_wd <= wd;

  owner_fixed_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ((own_reg & ~MUX_MASK) == ~MUX_MASK))
    else $error("unmuxed line lost controller ownership");
  unimpl_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd_acc && raddr == OFS_IRQ_PEND |=> (o_hrdata & ~IMPL_MASK) == 0)
    else $error("unimplemented line bit read nonzero");
  unimpl_wr_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    commit |=> ((oe_reg ^ $past(oe_reg)) & ~IMPL_MASK) == 0)
    else $error("unimplemented line state changed by write");
  out_guard_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    commit && waddr_reg == OFS_OUT_ST
    |=> ((out_reg ^ $past(out_reg)) & ~$past(dw_reg)) == 0)
    else $error("output level changed on line without direct write");
  pend_reset_a: assert property (@(posedge i_core_clk)
    $past(i_rst) && !i_rst |-> pend_reg == 0 && sel_lo_reg == 0 &&
      sel_hi_reg == 0)
    else $error("pending or select not zero after reset");
  cfg_reset_a: assert property (@(posedge i_core_clk)
    $past(i_rst) && !i_rst |-> !wg_on_reg && !wgv_reg && div_reg == 0 &&
      gf_reg == 0 && aim_reg == 0)
    else $error("guard, divider or filter not zero after reset");
  set_bit_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    wr_ok && waddr_reg == OFS_OE_SET |=> (oe_reg & d_wd) == d_wd)
    else $error("output enable set did not take effect");
  guard_block_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    commit && guarded |=> wgv_reg && wgsrc_reg == $past(waddr_reg) &&
      own_reg == $past(own_reg) && oe_reg == $past(oe_reg))
    else $error("guarded write not blocked or not logged");
  overrun_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    cap_take && cap_rdy_reg && !cap_dat_rd |=> cap_ovr_reg [*1])
    else $error("capture overrun not flagged");
  reserved_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    rd_acc && raddr == 12'h170 |=> o_hrdata == 0 ##1 !o_hresp)
    else $error("reserved offset read nonzero");
  pend_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (ev != 0) |=> (pend_reg & $past(ev)) == $past(ev))
    else $error("input event lost from pending");

  irq_read_c: cover property (@(posedge i_core_clk) pend_clr && o_irq);
  guard_hit_c: cover property (@(posedge i_core_clk) commit && guarded);
  overrun_c: cover property (@(posedge i_core_clk) $rose(cap_ovr_reg));
  direct_wr_c: cover property (@(posedge i_core_clk)
    commit && waddr_reg == OFS_OUT_ST && dw_reg != 0);

endmodule
`default_nettype wire
